/* hw/emb_pkg.sv */
// Shared constants and types for the external memory bank and bus hand-off block.
package emb_pkg;

  // ********************************************************************
  // Sizes of the external bus.
  // ********************************************************************
  localparam int EMB_BANKS = 6; // Number of ROM/SRAM/flash banks.
  localparam int EMB_ADDR_W = 22; // Width of the external address bus.
  localparam int EMB_LANES = 4; // Byte lanes on the data bus.
  localparam int EMB_DATA_W = 32; // Width of the data bus.
  localparam int EMB_MAP_W = 8; // Upper address bits compared by the bank map.
  localparam int EMB_BOOT_BANK = 0; // Bank that holds the boot program.
  localparam int EMB_SYNC_SETTLE = 4; // Edges after reset before synchronised straps are valid.

  // ********************************************************************
  // Bank width encodings and the byte lanes each one uses.
  // ********************************************************************
  localparam logic [1:0] EMB_WID_RSVD = 2'h0; // Reserved; treated as word.
  localparam logic [1:0] EMB_WID_BYTE = 2'h1; // Byte-wide bank.
  localparam logic [1:0] EMB_WID_HALF = 2'h2; // Half-word-wide bank.
  localparam logic [1:0] EMB_WID_WORD = 2'h3; // Word-wide bank.
  localparam logic [3:0] EMB_LANES_BYTE = 4'h1; // Lane mask of a byte bank.
  localparam logic [3:0] EMB_LANES_HALF = 4'h3; // Lane mask of a half-word bank.
  localparam logic [3:0] EMB_LANES_WORD = 4'hf; // Lane mask of a word bank.

  // Kind of memory that an access goes to.
  typedef enum logic [1:0] {EMB_ROM, EMB_DRAM, EMB_SDRAM} emb_kind_e;

  // One access request from the internal side.
  typedef struct packed {
    emb_kind_e kind;
    logic write;
    logic [EMB_LANES-1:0] be;
    logic [EMB_ADDR_W-1:0] addr;
    logic [EMB_DATA_W-1:0] wdata;
  } emb_req_s;

  // One entry of the bank map: upper address window and bank width.
  typedef struct packed {
    logic [EMB_MAP_W-1:0] base;
    logic [EMB_MAP_W-1:0] limit;
    logic [1:0] width;
  } emb_map_s;

  // Control and address pins of the external bus.
  typedef struct packed {
    logic [EMB_ADDR_W-1:0] addr;
    logic [EMB_BANKS-1:0] rom_bank_select_n;
    logic mem_output_enable_n;
    logic [EMB_LANES-1:0] byte_write_strobe_n;
    logic dram_write_strobe_n;
    logic [EMB_LANES-1:0] dram_col_strobe_n;
  } emb_pins_s;

  // Pin values while no access runs: all strobes inactive.
  localparam emb_pins_s EMB_PINS_IDLE = {{EMB_ADDR_W{1'b0}}, 6'h3f, 1'b1, 4'hf, 1'b1, 4'hf};

endpackage

/* hw/emb_pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module emb_pin_sync
  import emb_pkg::*;
#(
  parameter int W = 1 // Number of pins.
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_sync
);

  // ********************************************************************
  // Synchroniser stages.
  // ********************************************************************
  logic [W-1:0] s1_r; // First stage, read only by the second.
  logic [W-1:0] s2_r; // Second stage.
  logic [W-1:0] s3_r; // Third stage.
  logic [W-1:0] out_r; // Accepted level.
  logic [W-1:0] agree; // Bits where stages two and three agree.
  logic [W-1:0] out_nxt; // Next accepted level.

  initial begin
    if (W < 1) $error("emb_pin_sync needs at least one pin.");
  end

  assign agree = ~(s2_r ^ s3_r);
  assign out_nxt = (agree & s3_r) | (~agree & out_r);

  // Shift the pins in and take a bit only where the last two stages agree.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= pin_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign pin_sync = out_r;

endmodule // emb_pin_sync

/* hw/emb_ctrl.sv */
// External ROM/SRAM/flash bank controller with external bus master hand-off.
`timescale 1ns/100ps
module emb_ctrl
  import emb_pkg::*;
#(
  parameter int WAIT_CYC = 2, // Strobe cycles beyond the first on each access.
  parameter int BANKS = EMB_BANKS // Number of ROM/SRAM/flash banks.
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  input emb_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [EMB_DATA_W-1:0] rsp_data,
  input emb_map_s bank_map [BANKS],
  input wire logic [1:0] boot_bank_width,
  input wire logic little_pin,
  input wire logic ext_master_bus_request,
  output logic ext_master_bus_grant,
  output emb_pins_s pins,
  output logic pins_oe,
  output logic [EMB_DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic [EMB_DATA_W-1:0] data_i,
  output logic little_mode
);

  // ********************************************************************
  // Elaboration checks.
  // ********************************************************************
  initial begin
    if (BANKS != EMB_BANKS) $error("emb_ctrl serves exactly six banks.");
    if (WAIT_CYC < 0 || WAIT_CYC > 255) $error("emb_ctrl wait count out of range.");
  end

  localparam logic [7:0] WAIT_INIT = 8'(WAIT_CYC); // Loaded into the strobe counter.
  localparam logic [2:0] SETTLE = 3'(EMB_SYNC_SETTLE); // Strap settle count.

  // Access sequencer states.
  typedef enum logic [2:0] {ST_IDLE, ST_STROBE, ST_FLOAT, ST_GRANT} emb_state_e;

  // ********************************************************************
  // Pin synchronisers.
  // ********************************************************************
  logic [3:0] pins_s; // Synchronised request, byte order and width straps.
  logic ext_req_s; // Synchronised bus request.

  emb_pin_sync #(.W(4)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_async({ext_master_bus_request, little_pin, boot_bank_width}),
    .pin_sync(pins_s)
  );
  assign ext_req_s = pins_s[3];

  // ********************************************************************
  // Strap capture after reset release.
  // ********************************************************************
  logic [2:0] settle_r; // Cycles waited for the synchroniser to fill.
  logic strap_ok_r; // Straps have been captured.
  logic [1:0] boot_width_r; // Captured boot bank width.
  logic little_r; // Captured byte order, high for little endian.

  // Wait for the synchroniser to fill, then catch the straps once.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      settle_r <= '0;
      strap_ok_r <= 1'b0;
      boot_width_r <= EMB_WID_WORD;
      little_r <= 1'b0;
    end else if (!strap_ok_r) begin
      settle_r <= settle_r + 3'h1;
      if (settle_r == SETTLE) begin
        strap_ok_r <= 1'b1;
        boot_width_r <= pins_s[1:0];
        little_r <= pins_s[2];
      end
    end
  end

  // ********************************************************************
  // Bank decode from the mapping inputs.
  // ********************************************************************
  logic [EMB_MAP_W-1:0] addr_hi; // Upper address bits of the request.
  logic [BANKS-1:0] hit; // Banks whose window holds the address.
  logic [BANKS-1:0] sel; // Lowest hitting bank only.
  logic [1:0] bank_width [BANKS]; // Width of each bank.
  logic [1:0] sel_width; // Width of the selected bank.

  assign addr_hi = req.addr[EMB_ADDR_W-1 -: EMB_MAP_W];
  assign sel = hit & (~hit + 6'h01);

  // Each bank compares the address against its window; bank 0 uses the strap width.
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    assign hit[b] = (addr_hi >= bank_map[b].base) && (addr_hi < bank_map[b].limit);
    if (b == EMB_BOOT_BANK) begin : g_boot
      assign bank_width[b] = boot_width_r;
    end else begin : g_other
      assign bank_width[b] = bank_map[b].width;
    end
  end

  // Pick the width of the selected bank; no hit leaves word width.
  always_comb begin
    sel_width = EMB_WID_WORD;
    for (int b = BANKS - 1; b >= 0; b--) begin
      if (sel[b]) sel_width = bank_width[b];
    end
  end

  // ********************************************************************
  // Byte lanes and byte order.
  // ********************************************************************
  logic [3:0] width_lanes; // Lanes that the bank width allows.
  logic [3:0] be_ord; // Byte enables after byte order.
  logic [3:0] lane_en; // Lanes driven by this access.
  logic [EMB_DATA_W-1:0] wdata_ord; // Write data after byte order.
  logic [EMB_DATA_W-1:0] rdata_ord; // Read data after byte order.

  // Byte, half and word banks use one, two and four lanes; reserved counts as word.
  assign width_lanes = (req.kind != EMB_ROM) ? EMB_LANES_WORD :
                       (sel_width == EMB_WID_BYTE) ? EMB_LANES_BYTE :
                       (sel_width == EMB_WID_HALF) ? EMB_LANES_HALF : EMB_LANES_WORD;

  // Big endian mirrors the lanes; little endian passes them straight.
  for (genvar l = 0; l < EMB_LANES; l++) begin : g_lane
    assign be_ord[l] = little_r ? req.be[l] : req.be[EMB_LANES-1-l];
    assign wdata_ord[8*l +: 8] = little_r ? req.wdata[8*l +: 8] :
                                 req.wdata[8*(EMB_LANES-1-l) +: 8];
    assign rdata_ord[8*l +: 8] = little_r ? data_i[8*l +: 8] :
                                 data_i[8*(EMB_LANES-1-l) +: 8];
  end
  assign lane_en = be_ord & width_lanes;

  // ********************************************************************
  // Pin values for a new access.
  // ********************************************************************
  logic req_ready_r; // Ready for a new request.
  logic take; // Request accepted this cycle.
  logic is_rom; // Access goes to a ROM/SRAM/flash bank.
  logic is_dram; // Access goes to a plain DRAM bank.
  logic is_sdram; // Access goes to an SDRAM bank.
  emb_pins_s pins_new; // Pins to drive for the accepted access.

  assign take = req_valid && req_ready_r;
  assign is_rom = (req.kind == EMB_ROM);
  assign is_dram = (req.kind == EMB_DRAM);
  assign is_sdram = (req.kind == EMB_SDRAM);

  // Build the strobes of the accepted access by memory kind.
  always_comb begin
    pins_new = EMB_PINS_IDLE;
    pins_new.addr = req.addr;
    pins_new.rom_bank_select_n = is_rom ? ~sel : {BANKS{1'b1}};
    pins_new.mem_output_enable_n = req.write;
    if (is_rom && req.write) begin
      pins_new.byte_write_strobe_n = ~lane_en;
    end else if (is_sdram) begin
      pins_new.byte_write_strobe_n = ~lane_en;
    end
    if (is_dram) begin
      pins_new.dram_col_strobe_n = ~lane_en;
      pins_new.dram_write_strobe_n = ~req.write;
    end
  end

  // ********************************************************************
  // Access and hand-off sequencer.
  // ********************************************************************
  emb_state_e st_r; // Current state.
  emb_state_e st_nxt; // Next state.
  logic [7:0] wait_r; // Strobe cycles left.
  logic rsp_valid_r; // Read data or write completion pulse.
  logic [EMB_DATA_W-1:0] rsp_data_r; // Captured read data.
  logic grant_r; // Bus acknowledge to the external master.
  emb_pins_s pins_r; // Registered control pins.
  logic pins_oe_r; // Device drives control and address pins.
  logic [EMB_DATA_W-1:0] data_o_r; // Registered write data.
  logic data_oe_r; // Device drives the data bus.
  logic write_r; // Running access is a write.
  logic done; // Last strobe cycle.

  assign done = (st_r == ST_STROBE) && (wait_r == 8'h00);

  // Next state: a running access finishes before any hand-off.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (take) st_nxt = ST_STROBE;
        else if (ext_req_s) st_nxt = ST_FLOAT;
      end
      ST_STROBE: begin
        if (done) st_nxt = ST_IDLE;
      end
      ST_FLOAT: begin
        st_nxt = ST_GRANT;
      end
      ST_GRANT: begin
        if (!ext_req_s) st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // State, strobe counter and ready flag.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_r <= ST_IDLE;
      wait_r <= '0;
      req_ready_r <= 1'b0;
      write_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      wait_r <= take ? WAIT_INIT : (wait_r - {7'h00, (wait_r != 8'h00)});
      req_ready_r <= (st_nxt == ST_IDLE) && strap_ok_r && !ext_req_s && !take;
      if (take) write_r <= req.write;
    end
  end

  // Drive the pins for an access and return them to idle when it ends.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pins_r <= EMB_PINS_IDLE;
      data_o_r <= '0;
      data_oe_r <= 1'b0;
    end else if (take) begin
      pins_r <= pins_new;
      data_o_r <= wdata_ord;
      data_oe_r <= req.write;
    end else if (done) begin
      pins_r <= EMB_PINS_IDLE;
      data_oe_r <= 1'b0;
    end
  end

  // Float the bus before the grant and take it back when the grant drops.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pins_oe_r <= 1'b1;
      grant_r <= 1'b0;
    end else begin
      pins_oe_r <= (st_nxt == ST_IDLE) || (st_nxt == ST_STROBE);
      grant_r <= (st_nxt == ST_GRANT);
    end
  end

  // Report completion and capture read data.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= '0;
    end else begin
      rsp_valid_r <= done;
      if (done && !write_r) rsp_data_r <= rdata_ord;
    end
  end

  assign req_ready = req_ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign ext_master_bus_grant = grant_r;
  assign pins = pins_r;
  assign pins_oe = pins_oe_r;
  assign data_o = data_o_r;
  assign data_oe = data_oe_r;
  assign little_mode = little_r;

  // ********************************************************************
  // Assertions.
  // ********************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // At most one bank chip select is low.
  AST_ONE_CS: assert property ($onehot0(~pins_r.rom_bank_select_n))
    else $error("More than one bank chip select is active.");

  // The mapped bank is selected on the cycle after a ROM request is taken.
  AST_MAP_CS: assert property (take && is_rom |=> pins_r.rom_bank_select_n == ~$past(sel))
    else $error("Chip select does not match the bank map.");

  // A half-word boot bank never strobes the upper two lanes.
  AST_BOOT_HALF: assert property (!pins_r.rom_bank_select_n[0] && boot_width_r == EMB_WID_HALF
    && bank_map[0] == $past(bank_map[0]) |-> &pins_r.byte_write_strobe_n[3:2])
    else $error("Half-word boot bank strobed an upper lane.");

  // A byte-wide boot bank never strobes a lane above 0.
  AST_BOOT_BYTE: assert property (!pins_r.rom_bank_select_n[0] && boot_width_r == EMB_WID_BYTE
    |-> &pins_r.byte_write_strobe_n[3:1])
    else $error("Byte-wide boot bank strobed a lane above 0.");

  // A read drives output enable low on the first cycle after it is taken.
  AST_OE_READ: assert property (take && !req.write |=> !pins_r.mem_output_enable_n
    throughout (st_r == ST_STROBE)[*1])
    else $error("Output enable not active during a read.");

  // DRAM writes use the write strobe and never the byte strobes.
  AST_DRAM_WR: assert property (take && is_dram && req.write |=> !pins_r.dram_write_strobe_n
    && &pins_r.byte_write_strobe_n)
    else $error("DRAM write used the byte strobes.");

  // SDRAM accesses put the lane mask on the byte strobe pins.
  AST_SDRAM_MASK: assert property (take && is_sdram |=> pins_r.byte_write_strobe_n
    == ~$past(lane_en))
    else $error("SDRAM mask does not match the byte lanes.");

  // A request seen when idle floats the bus on the next cycle.
  AST_FLOAT: assert property (st_r == ST_IDLE && ext_req_s && !take |=> !pins_oe_r)
    else $error("Bus not floated after an external request.");

  // A withdrawn request drops the grant and retakes the bus.
  AST_RETAKE: assert property (grant_r && !ext_req_s |=> !grant_r && pins_oe_r)
    else $error("Bus not retaken after the request dropped.");

  // The grant rises only after the pins have floated for a cycle.
  AST_GRANT_LATE: assert property ($rose(grant_r) |-> !pins_oe_r && $past(!pins_oe_r))
    else $error("Grant rose before the bus floated.");

  // Big endian sends the top request byte on lane 0.
  AST_BIG_LANE: assert property (take && !little_r && req.write |=> data_o_r[7:0]
    == $past(req.wdata[31:24]))
    else $error("Big-endian byte order not applied.");

  // The pins stay driven for the whole of a running access.
  AST_FINISH: assert property (st_r == ST_STROBE |-> pins_oe_r && !grant_r)
    else $error("Bus floated during an access.");

  CVR_GRANT: cover property ($rose(grant_r));
  CVR_READ: cover property (rsp_valid_r && !write_r);
  CVR_REQ_IN_ACCESS: cover property (st_r == ST_STROBE && ext_req_s ##1 st_r == ST_STROBE);
  CVR_SDRAM: cover property (take && is_sdram);

endmodule // emb_ctrl

/* tb/emb_mem_model.sv */
// Behavioural model of the external ROM/SRAM/flash banks on the shared bus.
`timescale 1ns/100ps
module emb_mem_model
  import emb_pkg::*;
(
  input wire logic ref_clk,
  input emb_pins_s pins,
  input wire logic pins_oe,
  input wire logic [EMB_DATA_W-1:0] data_o,
  input wire logic data_oe,
  output logic [EMB_DATA_W-1:0] data_i
);
  // ********************************************************************
  // Storage and bus drive.
  // ********************************************************************
  logic [EMB_DATA_W-1:0] mem [1024]; // Word store shared by all banks.
  logic [EMB_DATA_W-1:0] last_r = '0; // Last word this model drove.
  wire sel = pins_oe && !(&pins.rom_bank_select_n); // Some bank is selected.
  wire rd = sel && !pins.mem_output_enable_n; // The selected bank puts out data.
  wire [9:0] idx = pins.addr[9:0]; // Word index into the store.
  // A released bus shows the inverse of the last word, so a stale value never matches.
  assign data_i = rd ? mem[idx] : ~last_r;
  // Remember the driven word and write the lanes whose strobe is low.
  always @(posedge ref_clk) begin
    if (rd) begin
      last_r <= mem[idx];
    end
    for (int l = 0; l < EMB_LANES; l++) begin
      if (sel && data_oe && !pins.byte_write_strobe_n[l]) begin
        mem[idx][l*8+:8] <= data_o[l*8+:8];
      end
    end
  end
endmodule // emb_mem_model

/* tb/ext_mem_bank_and_bus_handoff_bench.sv */
// Self-checking bench for the external bank controller and bus hand-off.
`timescale 1ns/100ps
module ext_mem_bank_and_bus_handoff_bench
  import emb_pkg::*;
;
  localparam int WAIT = 2; // Strobe cycles beyond the first.
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  emb_req_s req = '0;
  logic req_ready, rsp_valid, pins_oe, data_oe, little_mode, ext_master_bus_grant;
  logic [EMB_DATA_W-1:0] rsp_data, data_o, data_i, rdata, dseen;
  emb_map_s bank_map [EMB_BANKS];
  logic [1:0] boot_bank_width = EMB_WID_WORD;
  logic little_pin = 1'b0;
  logic ext_master_bus_request = 1'b0;
  emb_pins_s pins, seen;
  logic doe, stable;
  int mismatches = 0;
  int check_count = 0;
  int seed = 67;
  int lat;

  // The clock toggles every half period of 10 ns.
  always #5 ref_clk = ~ref_clk;

  emb_ctrl #(.WAIT_CYC(WAIT), .BANKS(EMB_BANKS)) i_dut (
    .ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .bank_map(bank_map), .boot_bank_width(boot_bank_width), .little_pin(little_pin),
    .ext_master_bus_request(ext_master_bus_request),
    .ext_master_bus_grant(ext_master_bus_grant), .pins(pins), .pins_oe(pins_oe),
    .data_o(data_o), .data_oe(data_oe), .data_i(data_i), .little_mode(little_mode));

  emb_mem_model i_mem (.ref_clk(ref_clk), .pins(pins), .pins_oe(pins_oe),
    .data_o(data_o), .data_oe(data_oe), .data_i(data_i));

  // ********************************************************************
  // Expectation helpers.
  // ********************************************************************
  // Lanes that a bank of the given width uses.
  function automatic logic [3:0] lanes_of(logic [1:0] w);
    return (w == EMB_WID_BYTE) ? EMB_LANES_BYTE : (w == EMB_WID_HALF) ? EMB_LANES_HALF
      : EMB_LANES_WORD;
  endfunction
  // Mirrors lane order for big-endian operation.
  function automatic logic [3:0] flip(logic [3:0] b);
    return {b[0], b[1], b[2], b[3]};
  endfunction
  // Widens a lane mask to a bit mask.
  function automatic logic [31:0] bytes_of(logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction

  // Counts a comparison and reports a mismatch at once.
  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One access: hold the request until taken, capture the strobe phase, await the answer.
  task automatic access(emb_kind_e k, logic wr, logic [3:0] be, logic [21:0] a,
                        logic [31:0] wd, logic grab);
    int n;
    n = 0;
    @(posedge ref_clk);
    // A grabbing master raises its request a cycle early, so it syncs mid-access.
    if (grab) begin
      ext_master_bus_request <= 1'b1;
      @(posedge ref_clk);
    end
    req_valid <= 1'b1;
    req <= '{k, wr, be, a, wd};
    #1;
    // Ready seen settled after an edge means the next edge takes the request.
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    req_valid <= 1'b0;
    @(posedge ref_clk);
    #1;
    seen = pins;
    dseen = data_o;
    doe = data_oe;
    lat = 1;
    stable = 1'b1;
    while (rsp_valid !== 1'b1 && lat < 300) begin
      @(posedge ref_clk);
      #1;
      lat++;
      if (rsp_valid !== 1'b1 && (pins !== seen || pins_oe !== 1'b1)) begin
        stable = 1'b0;
      end
    end
    rdata = rsp_data;
    check("request taken", n < 50, 1);
    check("latency", lat, WAIT + 1);
    check("pins stand", stable, 1);
    check("data drive", doe, wr);
  endtask

  // Write then read back one bank and compare strobes, selects and data.
  task automatic bank_test(int b, logic [1:0] w, logic lit);
    logic [3:0] be, bl;
    logic [31:0] wd, bus, m;
    logic [21:0] a;
    be = (b == 0) ? 4'hf : 4'($random(seed));
    wd = $random(seed);
    a = {bank_map[b].base, 4'h0, 10'($random(seed))};
    bl = (lit ? be : flip(be)) & lanes_of(w);
    bus = lit ? wd : {wd[7:0], wd[15:8], wd[23:16], wd[31:24]};
    access(EMB_ROM, 1'b1, be, a, wd, 1'b0);
    check("chip select", seen.rom_bank_select_n, 6'(~(6'h01 << b)));
    check("address", seen.addr, a);
    check("output enable on write", seen.mem_output_enable_n, 1);
    check("byte strobes", seen.byte_write_strobe_n, 4'(~bl));
    check("write data", dseen & bytes_of(bl), bus & bytes_of(bl));
    access(EMB_ROM, 1'b0, be, a, 32'h0, 1'b0);
    check("output enable on read", seen.mem_output_enable_n, 0);
    check("read strobes", seen.byte_write_strobe_n, 4'hf);
    m = bytes_of(lit ? bl : flip(bl));
    check("read data", rdata & m, wd & m);
  endtask

  // External master takes the bus, holds it, and hands it back.
  task automatic hand_off(logic raised);
    int n;
    logic prev;
    if (!raised) begin
      @(posedge ref_clk);
      ext_master_bus_request <= 1'b1;
    end
    n = 0;
    prev = 1'b1;
    while (ext_master_bus_grant !== 1'b1 && n < 20) begin
      prev = pins_oe;
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("grant rises", ext_master_bus_grant, 1);
    check("float before grant", prev, 0);
    check("pins floated", {pins_oe, data_oe}, 0);
    // The master would refresh any DRAM while it owns the bus.
    repeat (5) begin
      @(posedge ref_clk);
      #1;
      check("bus held", {ext_master_bus_grant, pins_oe, req_ready}, 3'b100);
    end
    @(posedge ref_clk);
    ext_master_bus_request <= 1'b0;
    n = 0;
    while (ext_master_bus_grant !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("grant falls", ext_master_bus_grant, 0);
    check("pins retaken", pins_oe, 1);
  endtask

  // ********************************************************************
  // Main sequence: both byte orders with each non-reserved boot width, every bank, all three memory kinds, hand-off.
  // ********************************************************************
  initial begin
    for (int b = 0; b < EMB_BANKS; b++) begin
      bank_map[b] <= '{8'(b * 16), 8'(b * 16 + 16), (b == 0) ? EMB_WID_RSVD : 2'(b % 3 + 1)};
    end
    for (int c = 0; c < 6; c++) begin
      @(posedge ref_clk);
      reset <= 1'b1;
      boot_bank_width <= 2'(c % 3 + 1);
      little_pin <= 1'(c / 3);
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      for (int b = 0; b < EMB_BANKS; b++) begin
        bank_test(b, (b == 0) ? 2'(c % 3 + 1) : bank_map[b].width, 1'(c / 3));
      end
      check("byte order", little_mode, c / 3);
      access(EMB_ROM, 1'b0, 4'hf, {8'hf0, 14'h0}, 32'h0, 1'b0);
      check("unmapped select", seen.rom_bank_select_n, 6'h3f);
      access(EMB_DRAM, 1'b1, 4'hf, {8'h30, 14'h5}, $random(seed), 1'b0);
      check("dram byte strobes", seen.byte_write_strobe_n, 4'hf);
      check("dram write strobe", seen.dram_write_strobe_n, 0);
      check("dram column strobes", seen.dram_col_strobe_n, 4'h0);
      access(EMB_SDRAM, 1'(c % 2), 4'hf, {8'h30, 14'h9}, $random(seed), 1'b0);
      check("sdram mask", seen.byte_write_strobe_n, 4'h0);
      check("sdram select", seen.rom_bank_select_n, 6'h3f);
      if (c % 2 == 1) begin
        access(EMB_ROM, 1'b0, 4'hf, {8'h00, 14'h7}, 32'h0, 1'b1);
      end
      hand_off(c % 2 == 1);
      $display("test config %0d done", c);
    end
    end_of_test();
  end

  // Cuts a hang short well beyond the expected run of about 720 cycles.
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule // ext_mem_bank_and_bus_handoff_bench
